// ### logic/adc_result_regs_pkg.sv
// package: register map, fields and types for the converter result/config block
package adc_result_regs_pkg;

    localparam logic [11:0] OFF_RESULT_HIGH  = 12'h000;
    localparam logic [11:0] OFF_RESULT_LOW   = 12'h004;
    localparam logic [11:0] OFF_COMPARE_HIGH = 12'h008;
    localparam logic [11:0] OFF_COMPARE_LOW  = 12'h00C;
    localparam logic [11:0] OFF_CONFIG       = 12'h010;
    localparam logic [11:0] OFF_PIN_DISABLE  = 12'h014;
    localparam logic [11:0] OFF_CONTROL      = 12'h018;
    localparam logic [11:0] OFF_IRQ_STATUS   = 12'h01C;
    localparam logic [11:0] OFF_IRQ_MASK     = 12'h020;

    localparam int CFG_LOW_POWER_BIT = 7;
    localparam int CFG_DIV_LSB       = 5;
    localparam int CFG_LONG_SAMP_BIT = 4;
    localparam int CFG_MODE_LSB      = 2;
    localparam int CFG_CLKSEL_LSB    = 0;

    localparam int CTL_COMPARE_EN_BIT = 0;
    localparam int CTL_GREATER_EQ_BIT = 1;

    localparam int IRQ_DONE_BIT    = 0;
    localparam int IRQ_DROPPED_BIT = 1;

    localparam logic [1:0] MODE_8BIT  = 2'b00;
    localparam logic [1:0] MODE_10BIT = 2'b10;

    localparam logic [7:0] CONFIG_RESET  = 8'h00;
    localparam logic [7:0] PIN_RESET     = 8'h00;
    localparam logic [7:0] COMPARE_RESET = 8'h00;
    localparam logic [1:0] CONTROL_RESET = 2'b00;
    localparam logic [1:0] IRQ_RESET     = 2'b00;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } apb_rsp_t;

    typedef struct packed {
        logic       lowPower;
        logic [1:0] clockDivide;
        logic       longSample;
        logic [1:0] resolution;
        logic [1:0] inputClock;
    } converter_cfg_t;

endpackage

// ### logic/adc_result_regs.sv
// converter result, compare, configuration and pin disable registers on apb
//
// Our own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
// Function
// - result bits 9:8 appear in bits 1:0 of the high result register
// - in 8-bit resolution high result bits 8 and 9 read zero
// - load results each completion unless compare enabled and condition fails
// - 10-bit: high result read blocks later transfers until low result read
// - completions during the interlock are discarded
// - 8-bit mode has no interlock; every result that passes any enabled compare transfers
// - a resolution change invalidates both result registers until next completion
// - low result holds bits 7:0, or the whole 8-bit result
// - compare high bits 9:8 used only in 10-bit mode
// - compare low bits 7:0 compared against lower result bits in both modes
// - config bit 7 selects high speed (0) or low power (1)
// - config bits 6:5 divide input clock by 1, 2, 4 or 8
// - config bit 4 selects short (0) or long (1) sample time
// - config bits 3:2 select 8-bit (00) or 10-bit (10) resolution
// - config bits 1:0 select bus, bus/2, alternate or internal clock
// - pin disable bit n: 1 disables port control of channel n pin
// - a placed result sets the done flag and may raise an interrupt
// - compare true on less-than, or greater-or-equal when selected
module adc_result_regs (
    input  wire logic                               clock,
    input  wire logic                               rst_n,
    input  wire adc_result_regs_pkg::apb_req_t      apbReq,
    output adc_result_regs_pkg::apb_rsp_t           apbRsp,
    input  wire logic                               convDone,
    input  wire logic [9:0]                         convData,
    input  wire logic                               alternateClock,
    input  wire logic                               internalAsyncClock,
    output adc_result_regs_pkg::converter_cfg_t     converterCfg,
    output logic                                    converterClockEnable,
    output logic                                    resultValid,
    output logic [7:0]                              pinDisable,
    output logic                                    irq
);
    import adc_result_regs_pkg::*;

    typedef struct packed {
        logic [9:0]     result;
        logic           valid;
        logic           locked;
        logic [7:0]     cmpHigh;
        logic [7:0]     cmpLow;
        converter_cfg_t cfg;
        logic [7:0]     pins;
        logic [1:0]     control;
        logic [1:0]     status;
        logic [1:0]     mask;
        logic [2:0]     divCount;
        logic           busHalf;
        logic [1:0]     altSync;
        logic [1:0]     asyncSync;
        logic           altPrev;
        logic           asyncPrev;
        logic           ckEnable;
        logic [31:0]    rdata;
        logic           done;
        logic           dataDone;
        logic [9:0]     dataSync;
        logic           readPending;
    } state_t;

    state_t state_reg;
    state_t state_next;

    function automatic logic [7:0] cfg_to_byte(input converter_cfg_t c);
        cfg_to_byte = {c.lowPower, c.clockDivide, c.longSample, c.resolution, c.inputClock};
    endfunction

    function automatic logic [3:0] divide_ratio(input logic [1:0] code);
        unique case (code)
            2'b00: divide_ratio = 4'd1;
            2'b01: divide_ratio = 4'd2;
            2'b10: divide_ratio = 4'd4;
            2'b11: divide_ratio = 4'd8;
        endcase
    endfunction

    logic       apbAccess;
    logic       apbWrite;
    logic       apbRead;
    logic       mapped;
    logic       tenBit;
    logic [9:0] cmpValue;
    logic [9:0] cmpSubject;
    logic       cmpLess;
    logic       cmpPass;
    logic       sourceTick;
    logic [3:0] ratio;
    logic [7:0] cfgWrite;
    logic       loadNow;

    always_comb begin
        apbAccess = apbReq.psel && apbReq.penable;
        apbWrite = apbAccess && apbReq.pwrite;
        apbRead = apbAccess && !apbReq.pwrite;
        unique case (apbReq.paddr)
            OFF_RESULT_HIGH, OFF_RESULT_LOW, OFF_COMPARE_HIGH, OFF_COMPARE_LOW,
            OFF_CONFIG, OFF_PIN_DISABLE, OFF_CONTROL, OFF_IRQ_STATUS,
            OFF_IRQ_MASK: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
        tenBit = (state_reg.cfg.resolution == MODE_10BIT);
        // 8-bit mode ignores the high compare byte entirely
        if (tenBit) begin
            cmpValue = {state_reg.cmpHigh[1:0], state_reg.cmpLow};
            cmpSubject = state_reg.dataSync;
        end else begin
            cmpValue = {2'b00, state_reg.cmpLow};
            cmpSubject = {2'b00, state_reg.dataSync[7:0]};
        end
        cmpLess = (cmpSubject < cmpValue);
        cmpPass = state_reg.control[CTL_GREATER_EQ_BIT] ? !cmpLess : cmpLess;
        loadNow = state_reg.done && !(state_reg.locked && tenBit)
            && (!state_reg.control[CTL_COMPARE_EN_BIT] || cmpPass);
        unique case (state_reg.cfg.inputClock)
            2'b00: sourceTick = 1'b1;
            2'b01: sourceTick = state_reg.busHalf;
            2'b10: sourceTick = state_reg.altSync[1] && !state_reg.altPrev;
            2'b11: sourceTick = state_reg.asyncSync[1] && !state_reg.asyncPrev;
        endcase
        ratio = divide_ratio(state_reg.cfg.clockDivide);
        cfgWrite = apbReq.pwdata[7:0];
    end

    always_comb begin
        state_next = state_reg;
        state_next.ckEnable = 1'b0;
        state_next.readPending = apbRead && !state_reg.readPending;
        // convDone is registered once so result and compare see aligned data
        state_next.done = convDone;
        state_next.dataDone = state_reg.done;
        if (convDone) begin
            state_next.dataSync = convData;
        end
        state_next.busHalf = !state_reg.busHalf;
        state_next.altSync = {state_reg.altSync[0], alternateClock};
        state_next.asyncSync = {state_reg.asyncSync[0], internalAsyncClock};
        state_next.altPrev = state_reg.altSync[1];
        state_next.asyncPrev = state_reg.asyncSync[1];
        // converter clock as enable pulses: selected source divided by ratio
        if (sourceTick) begin
            if ({1'b0, state_reg.divCount} >= ratio - 4'd1) begin
                state_next.divCount = 3'd0;
                state_next.ckEnable = 1'b1;
            end else begin
                state_next.divCount = state_reg.divCount + 3'd1;
            end
        end
        if (state_reg.done) begin
            if (state_reg.locked && tenBit) begin
                state_next.status[IRQ_DROPPED_BIT] = 1'b1;
            end else if (loadNow) begin
                state_next.result = tenBit ? state_reg.dataSync : {2'b00, state_reg.dataSync[7:0]};
                state_next.valid = 1'b1;
                state_next.status[IRQ_DONE_BIT] = 1'b1;
            end
        end
        state_next.rdata = 32'h0000_0000;
        if (apbRead) begin
            unique case (apbReq.paddr)
                OFF_RESULT_HIGH: begin
                    state_next.rdata = {30'h0, tenBit ? state_reg.result[9:8] : 2'b00};
                    if (tenBit) begin
                        state_next.locked = 1'b1;
                    end
                end
                OFF_RESULT_LOW: begin
                    state_next.rdata = {24'h0, state_reg.result[7:0]};
                    state_next.locked = 1'b0;
                end
                OFF_COMPARE_HIGH: state_next.rdata = {30'h0, state_reg.cmpHigh[1:0]};
                OFF_COMPARE_LOW: state_next.rdata = {24'h0, state_reg.cmpLow};
                OFF_CONFIG: state_next.rdata = {24'h0, cfg_to_byte(state_reg.cfg)};
                OFF_PIN_DISABLE: state_next.rdata = {24'h0, state_reg.pins};
                OFF_CONTROL: state_next.rdata = {30'h0, state_reg.control};
                OFF_IRQ_STATUS: state_next.rdata = {30'h0, state_reg.status};
                OFF_IRQ_MASK: state_next.rdata = {30'h0, state_reg.mask};
                default: state_next.rdata = 32'h0000_0000;
            endcase
        end
        if (!tenBit) begin
            state_next.locked = 1'b0;
        end
        if (apbWrite) begin
            unique case (apbReq.paddr)
                OFF_COMPARE_HIGH: state_next.cmpHigh = {6'h00, apbReq.pwdata[1:0]};
                OFF_COMPARE_LOW: state_next.cmpLow = apbReq.pwdata[7:0];
                OFF_CONFIG: begin
                    state_next.cfg.lowPower = cfgWrite[CFG_LOW_POWER_BIT];
                    state_next.cfg.clockDivide = cfgWrite[CFG_DIV_LSB +: 2];
                    state_next.cfg.longSample = cfgWrite[CFG_LONG_SAMP_BIT];
                    state_next.cfg.resolution = cfgWrite[CFG_MODE_LSB +: 2];
                    state_next.cfg.inputClock = cfgWrite[CFG_CLKSEL_LSB +: 2];
                    // the completion in this same cycle still wins and revalidates
                    if (cfgWrite[CFG_MODE_LSB +: 2] != state_reg.cfg.resolution) begin
                        if (!loadNow) begin
                            state_next.valid = 1'b0;
                        end
                        state_next.locked = 1'b0;
                    end
                end
                OFF_PIN_DISABLE: state_next.pins = apbReq.pwdata[7:0];
                OFF_CONTROL: state_next.control = apbReq.pwdata[1:0];
                // write-one-to-clear; a same-cycle set survives unless the bit was already set
                OFF_IRQ_STATUS: state_next.status = state_next.status
                    & ~(apbReq.pwdata[1:0] & ~(state_next.status & ~state_reg.status));
                OFF_IRQ_MASK: state_next.mask = apbReq.pwdata[1:0];
                default: state_next.mask = state_next.mask;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_reg <= '0;
            state_reg.cfg <= converter_cfg_t'(CONFIG_RESET);
            state_reg.pins <= PIN_RESET;
            state_reg.cmpHigh <= COMPARE_RESET;
            state_reg.cmpLow <= COMPARE_RESET;
            state_reg.control <= CONTROL_RESET;
            state_reg.status <= IRQ_RESET;
            state_reg.mask <= IRQ_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // read data is registered, so pready lags one cycle on reads
    always_comb begin
        apbRsp.pready = apbReq.pwrite ? 1'b1 : state_reg.readPending;
        apbRsp.pslverr = apbAccess && !mapped;
        apbRsp.prdata = state_reg.rdata;
        converterCfg = state_reg.cfg;
        converterClockEnable = state_reg.ckEnable;
        resultValid = state_reg.valid;
        pinDisable = state_reg.pins;
        irq = |(state_reg.status & state_reg.mask);
    end

endmodule

// ### dv/adc_result_regs_chk.sv
// checker: port-level assertions for the converter register block
`timescale 1ns/100ps
module adc_result_regs_chk (
    input wire logic                               clock,
    input wire logic                               rst_n,
    input wire adc_result_regs_pkg::apb_req_t      apbReq,
    input wire adc_result_regs_pkg::apb_rsp_t      apbRsp,
    input wire logic                               convDone,
    input wire adc_result_regs_pkg::converter_cfg_t converterCfg,
    input wire logic                               converterClockEnable,
    input wire logic                               resultValid,
    input wire logic [7:0]                         pinDisable
);
    import adc_result_regs_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    wire acc   = apbReq.psel && apbReq.penable;
    wire wrOk  = acc && apbReq.pwrite && apbRsp.pready;
    wire rdOk  = acc && !apbReq.pwrite && apbRsp.pready;
    wire wrCfg = wrOk && apbReq.paddr == OFF_CONFIG;
    sequence ready_after_wait;
        !apbRsp.pready ##1 apbRsp.pready;
    endsequence
    sequence div8_gap;
        (!converterClockEnable) [*7] ##1 converterClockEnable;
    endsequence
    cfg_mirror_a: assert property (
        wrCfg |=> converterCfg == $past(apbReq.pwdata[7:0]))
        else $error("config outputs differ from written byte");
    pin_mirror_a: assert property (
        wrOk && apbReq.paddr == OFF_PIN_DISABLE |=> pinDisable == $past(apbReq.pwdata[7:0]))
        else $error("pin disable outputs differ from written byte");
    mode_invalid_a: assert property (
        wrCfg && apbReq.pwdata[3:2] != converterCfg.resolution && !$past(convDone)
        |=> !resultValid)
        else $error("results still valid after mode change");
    valid_cause_a: assert property (
        $rose(resultValid) |-> $past(convDone, 2))
        else $error("results became valid without a completion");
    high_zero_a: assert property (
        rdOk && apbReq.paddr == OFF_RESULT_HIGH && converterCfg.resolution != MODE_10BIT
        |-> apbRsp.prdata == 32'h0000_0000)
        else $error("high result nonzero in 8-bit mode");
    high_upper_a: assert property (
        rdOk && apbReq.paddr == OFF_RESULT_HIGH |-> apbRsp.prdata[31:2] == '0)
        else $error("high result uses bits above 1");
    low_byte_a: assert property (
        rdOk && apbReq.paddr == OFF_RESULT_LOW |-> apbRsp.prdata[31:8] == '0)
        else $error("low result uses bits above 7");
    read_wait_a: assert property (
        acc && !apbReq.pwrite && !$past(apbReq.penable) && apbReq.paddr <= OFF_IRQ_MASK
        |-> ready_after_wait)
        else $error("read answer not after one wait cycle");
    write_ready_a: assert property (
        acc && apbReq.pwrite |-> apbRsp.pready)
        else $error("write access not answered at once");
    div_eight_a: assert property (
        converterClockEnable && converterCfg.clockDivide == 2'b11
        && converterCfg.inputClock == 2'b00 |=> div8_gap)
        else $error("divide by eight tick spacing wrong");
endmodule
bind adc_result_regs adc_result_regs_chk u_chk (.clock(clock), .rst_n(rst_n),
    .apbReq(apbReq), .apbRsp(apbRsp), .convDone(convDone), .converterCfg(converterCfg),
    .converterClockEnable(converterClockEnable), .resultValid(resultValid),
    .pinDisable(pinDisable));

// ### dv/conv_core_model.sv
// conversion core stand-in: result pulses and the two async clocks
`timescale 1ns/100ps
module conv_core_model (
    input  wire logic       clock,
    output logic            convDone,
    output logic [9:0]      convData,
    output logic            alternateClock,
    output logic            internalAsyncClock
);
    initial begin
        convDone = 1'b0;
        convData = 10'h000;
        alternateClock = 1'b0;
        internalAsyncClock = 1'b0;
    end
    always #7.3 alternateClock = !alternateClock;
    always #11.1 internalAsyncClock = !internalAsyncClock;
    // idle data is inverted so a late sample never matches by luck
    task automatic convert(input logic [9:0] v, input int waitCycles);
        repeat (waitCycles) @(posedge clock);
        convDone <= 1'b1;
        convData <= v;
        @(posedge clock);
        convDone <= 1'b0;
        convData <= ~v;
    endtask
endmodule

// ### dv/adc_result_regs_tb_top.sv
// self-checking bench: apb register tests against the converter core model
`timescale 1ns/100ps
module adc_result_regs_tb_top;
    import adc_result_regs_pkg::*;
    logic           clock, rst_n, convDone, alternate_clock, asyncClk, ckEn, rv, irq, err;
    apb_req_t       req;
    apb_rsp_t       rsp;
    converter_cfg_t cfg;
    logic [9:0]     convData;
    logic [7:0]     pins, d;
    logic [31:0]    q;
    int             mismatches, comparisons, tickCount;
    adc_result_regs u_dut (.clock(clock), .rst_n(rst_n), .apbReq(req), .apbRsp(rsp),
        .convDone(convDone), .convData(convData), .alternateClock(alternate_clock),
        .internalAsyncClock(asyncClk), .converterCfg(cfg), .converterClockEnable(ckEn),
        .resultValid(rv), .pinDisable(pins), .irq(irq));
    conv_core_model u_core (.clock(clock), .convDone(convDone), .convData(convData),
        .alternateClock(alternate_clock), .internalAsyncClock(asyncClk));
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // holds the request until pready is seen at an edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        @(posedge clock);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
        @(posedge clock);
        req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (rsp.pready !== 1'b1 && n < 20);
        q = rsp.prdata;
        err = rsp.pslverr;
        if (n >= 20) begin
            mismatches++;
            close_out();
        end
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        // registers launched at the ready edge are only settled by mid-cycle
        @(negedge clock);
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk($sformatf("reg %h", a), q, exp);
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] v);
        apb(1'b1, a, {24'h00_0000, v});
    endtask
    task automatic conv(input logic [9:0] v, input int dly);
        u_core.convert(v, dly);
        repeat (3) @(posedge clock);
    endtask
    task automatic ticks(input logic [7:0] c, output int cnt);
        wr(OFF_CONFIG, c);
        cnt = 0;
        repeat (40) begin
            @(posedge clock);
            cnt += int'(ckEn);
        end
    endtask
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    initial begin
        rst_n = 1'b0;
        req = '0;
        mismatches = 0;
        comparisons = 0;
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        for (int a = 8; a <= 32; a += 4) rchk(a[11:0], 32'h0000_0000);
        apb(1'b0, 12'h024, 32'h0000_0000);
        chk("slverr", 32'(err), 32'h0000_0001);
        for (int i = 0; i < 4; i++) begin
            d = {i[0], i[1:0], i[1], i[1], 1'b0, i[1:0]};
            wr(OFF_CONFIG, d);
            chk("cfg", 32'(cfg), 32'(d));
            rchk(OFF_CONFIG, 32'(d));
        end
        wr(OFF_PIN_DISABLE, 8'hA5);
        chk("pins", 32'(pins), 32'h0000_00A5);
        $display("test registers done");
        wr(OFF_IRQ_MASK, 8'h01);
        wr(OFF_CONFIG, 8'h00);
        conv(10'h3C5, 1);
        chk("irq", 32'(irq), 32'h0000_0001);
        rchk(OFF_RESULT_HIGH, 32'h0000_0000);
        rchk(OFF_RESULT_LOW, 32'h0000_00C5);
        wr(OFF_IRQ_STATUS, 8'h01);
        wr(OFF_IRQ_MASK, 8'h00);
        chk("irq", 32'(irq), 32'h0000_0000);
        rchk(OFF_RESULT_HIGH, 32'h0000_0000);
        conv(10'h0F0, 4);
        chk("irq", 32'(irq), 32'h0000_0000);
        rchk(OFF_RESULT_LOW, 32'h0000_00F0);
        $display("test 8-bit results done");
        wr(OFF_CONFIG, 8'h08);
        chk("valid", 32'(rv), 32'h0000_0000);
        conv(10'h2A7, 1);
        chk("valid", 32'(rv), 32'h0000_0001);
        rchk(OFF_RESULT_HIGH, 32'h0000_0002);
        conv(10'h155, 2);
        rchk(OFF_RESULT_LOW, 32'h0000_00A7);
        rchk(OFF_IRQ_STATUS, 32'h0000_0003);
        conv(10'h155, 1);
        rchk(OFF_RESULT_HIGH, 32'h0000_0001);
        rchk(OFF_RESULT_LOW, 32'h0000_0055);
        $display("test interlock done");
        wr(OFF_COMPARE_HIGH, 8'h02);
        wr(OFF_COMPARE_LOW, 8'h00);
        wr(OFF_CONTROL, 8'h01);
        conv(10'h1FF, 1);
        rchk(OFF_RESULT_LOW, 32'h0000_00FF);
        conv(10'h300, 1);
        rchk(OFF_RESULT_HIGH, 32'h0000_0001);
        rchk(OFF_RESULT_LOW, 32'h0000_00FF);
        wr(OFF_CONFIG, 8'h00);
        wr(OFF_CONTROL, 8'h03);
        wr(OFF_COMPARE_LOW, 8'h80);
        conv(10'h090, 1);
        rchk(OFF_RESULT_LOW, 32'h0000_0090);
        conv(10'h070, 1);
        rchk(OFF_RESULT_LOW, 32'h0000_0090);
        $display("test compare done");
        // a 40-cycle window holds four divide-by-eight ticks plus one left over from the divide-by-one setting
        ticks(8'h60, tickCount);
        chk("div8 ticks", 32'(tickCount), 32'h0000_0005);
        ticks(8'h02, tickCount);
        chk("alt ticks", 32'(tickCount >= 12 && tickCount <= 15), 32'h0000_0001);
        ticks(8'h03, tickCount);
        chk("async ticks", 32'(tickCount >= 8 && tickCount <= 11), 32'h0000_0001);
        $display("test clock divide done");
        close_out();
    end
endmodule
